// file: dual_burst_pkg.sv
// Notes on behaviour
// R1: mode 010 routes driver A from cpu_port_pin
// R2: mode 010 drives driver B from generator B
// R3: writing 1 to B trigger starts burst B
// R4: driver B emits exactly pulse count B pulses
// R5: generator B uses 11-bit high/low times
// R6: generator A uses 11-bit high/low times
// R7: mode 011 drives A and B from generators
// R8: writing 1 to A trigger starts burst A
// R9: driver A emits exactly pulse count A pulses
// R10: after burst, output stays off until retrigger
// R11: each pulse is high time then low time
package dual_burst_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int TIME_W = 11;
  localparam int COUNT_W = 6;
  localparam int MODE_W = 3;

  // register offsets (word index on the plain port)
  localparam logic [ADDR_W-1:0] OFF_MODE = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_HIGH_TIME_A = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_LOW_TIME_A = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_HIGH_TIME_B = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_LOW_TIME_B = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_COUNT_A = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_COUNT_B = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;

  // field positions
  localparam int EN_A_BIT = 0;
  localparam int EN_B_BIT = 1;
  localparam int ST_BUSY_A_BIT = 0;
  localparam int ST_BUSY_B_BIT = 1;
  localparam int ST_DRV_A_BIT = 2;
  localparam int ST_DRV_B_BIT = 3;

  // drive-source codes
  localparam logic [MODE_W-1:0] MODE_PORT_PIN = 3'h2;
  localparam logic [MODE_W-1:0] MODE_DUAL = 3'h3;

  // reset values
  localparam logic [MODE_W-1:0] MODE_RST = 3'h3;
  localparam logic [TIME_W-1:0] TIME_RST = 11'h008;
  localparam logic [COUNT_W-1:0] COUNT_RST = 6'h00;

  typedef enum logic [1:0] {BURST_IDLE, BURST_HIGH, BURST_LOW} burst_state_e;

endpackage

// file: burst_channel.sv
`timescale 1ns/1ps
module burst_channel
  import dual_burst_pkg::*;
#(
  parameter int TW = 11,
  parameter int CW = 6
)
(
  input wire logic clk_in, // burst clock
  input wire logic rst_n_in, // synchronised reset, active low
  input wire logic start_in, // one-cycle trigger
  input wire logic [TW-1:0] high_time_in, // high cycles
  input wire logic [TW-1:0] low_time_in, // low cycles
  input wire logic [CW-1:0] count_in, // pulses per burst
  output logic drive_out, // pulse train
  output logic busy_out // burst running
);
  import dual_burst_pkg::*;

  burst_state_e state_reg, state_next;
  logic [TW-1:0] cnt_reg, cnt_next;
  logic [TW-1:0] hi_reg, hi_next;
  logic [TW-1:0] lo_reg, lo_next;
  logic [CW-1:0] left_reg, left_next;
  logic drive_reg, drive_next;
  wire phase_done = (cnt_reg <= {{(TW-1){1'b0}}, 1'b1});
  wire last_pulse = (left_reg == {{(CW-1){1'b0}}, 1'b1});

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    hi_next = hi_reg;
    lo_next = lo_reg;
    left_next = left_reg;
    drive_next = drive_reg;
    if (start_in)
    begin
      // times latched so mid-burst writes cannot tear a pulse
      hi_next = high_time_in;
      lo_next = low_time_in;
      left_next = count_in;
      cnt_next = high_time_in;
      if (count_in == '0)
      begin
        state_next = BURST_IDLE; // see R4 see R9
        drive_next = 1'b0;
      end
      else
      begin
        state_next = BURST_HIGH;
        drive_next = 1'b1;
      end
    end
    else
    begin
      unique case (state_reg)
        BURST_IDLE:
        begin
          drive_next = 1'b0; // see R10
        end
        BURST_HIGH:
        begin
          if (phase_done)
          begin
            state_next = BURST_LOW; // see R11
            cnt_next = lo_reg;
            drive_next = 1'b0;
          end
          else
            cnt_next = cnt_reg - 1'b1;
        end
        BURST_LOW:
        begin
          if (!phase_done)
            cnt_next = cnt_reg - 1'b1;
          else if (last_pulse)
          begin
            state_next = BURST_IDLE; // see R10
            left_next = '0;
          end
          else
          begin
            state_next = BURST_HIGH; // see R11
            cnt_next = hi_reg;
            left_next = left_reg - 1'b1;
            drive_next = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= BURST_IDLE;
      cnt_reg <= '0;
      hi_reg <= '0;
      lo_reg <= '0;
      left_reg <= '0;
      drive_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      hi_reg <= hi_next;
      lo_reg <= lo_next;
      left_reg <= left_next;
      drive_reg <= drive_next;
    end
  end

  assign drive_out = drive_reg;
  assign busy_out = (state_reg != BURST_IDLE);

endmodule // burst_channel

// file: dual_burst_generator.sv
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module dual_burst_generator
  import dual_burst_pkg::*;
(
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic [dual_burst_pkg::ADDR_W-1:0] addr_in, // register index
  input wire logic [dual_burst_pkg::DATA_W-1:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  input wire logic cpu_port_pin_in, // processor port pin level
  output logic [dual_burst_pkg::DATA_W-1:0] rdata_out, // read data
  output logic low_side_driver_a_out, // driver A gate
  output logic low_side_driver_b_out // driver B gate
);
  import dual_burst_pkg::*;

  logic rst_meta_reg;
  logic rst_sync_reg;

  logic [MODE_W-1:0] mode_reg;
  logic [TIME_W-1:0] high_time_a_reg;
  logic [TIME_W-1:0] low_time_a_reg;
  logic [TIME_W-1:0] high_time_b_reg;
  logic [TIME_W-1:0] low_time_b_reg;
  logic [COUNT_W-1:0] count_a_reg;
  logic [COUNT_W-1:0] count_b_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic drv_a_reg;
  logic drv_b_reg;

  logic gen_a_drive;
  logic gen_b_drive;
  logic gen_a_busy;
  logic gen_b_busy;

  // reset release through two flops
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // write decode
  wire wr_mode = wr_in && (addr_in == OFF_MODE);
  wire wr_enable = wr_in && (addr_in == OFF_ENABLE);
  wire wr_high_a = wr_in && (addr_in == OFF_HIGH_TIME_A);
  wire wr_low_a = wr_in && (addr_in == OFF_LOW_TIME_A);
  wire wr_high_b = wr_in && (addr_in == OFF_HIGH_TIME_B);
  wire wr_low_b = wr_in && (addr_in == OFF_LOW_TIME_B);
  wire wr_count_a = wr_in && (addr_in == OFF_COUNT_A);
  wire wr_count_b = wr_in && (addr_in == OFF_COUNT_B);

  // trigger bits are write-one strobes and never stored
  wire start_a = wr_enable && wdata_in[EN_A_BIT]; // see R8
  wire start_b = wr_enable && wdata_in[EN_B_BIT]; // see R3

  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      mode_reg <= MODE_RST;
    else if (wr_mode)
      mode_reg <= wdata_in[MODE_W-1:0];
  end

  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      high_time_a_reg <= TIME_RST;
    else if (wr_high_a)
      high_time_a_reg <= wdata_in[TIME_W-1:0]; // see R6
  end

  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      low_time_a_reg <= TIME_RST;
    else if (wr_low_a)
      low_time_a_reg <= wdata_in[TIME_W-1:0]; // see R6
  end

  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      high_time_b_reg <= TIME_RST;
    else if (wr_high_b)
      high_time_b_reg <= wdata_in[TIME_W-1:0]; // see R5
  end

  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      low_time_b_reg <= TIME_RST;
    else if (wr_low_b)
      low_time_b_reg <= wdata_in[TIME_W-1:0]; // see R5
  end

  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      count_a_reg <= COUNT_RST;
    else if (wr_count_a)
      count_a_reg <= wdata_in[COUNT_W-1:0]; // see R9
  end

  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      count_b_reg <= COUNT_RST;
    else if (wr_count_b)
      count_b_reg <= wdata_in[COUNT_W-1:0]; // see R4
  end

  // a write to a parameter register in the same cycle as its trigger
  // is not seen by that burst; the channel latches the old value
  burst_channel #(
    .TW(TIME_W),
    .CW(COUNT_W)
  ) gen_a (
    .clk_in(clk_in),
    .rst_n_in(rst_sync_reg),
    .start_in(start_a), // see R8
    .high_time_in(high_time_a_reg),
    .low_time_in(low_time_a_reg),
    .count_in(count_a_reg),
    .drive_out(gen_a_drive),
    .busy_out(gen_a_busy)
  );

  burst_channel #(
    .TW(TIME_W),
    .CW(COUNT_W)
  ) gen_b (
    .clk_in(clk_in),
    .rst_n_in(rst_sync_reg),
    .start_in(start_b), // see R3
    .high_time_in(high_time_b_reg),
    .low_time_in(low_time_b_reg),
    .count_in(count_b_reg),
    .drive_out(gen_b_drive),
    .busy_out(gen_b_busy)
  );

  // drive-source selection; unsupported codes keep both drivers off
  wire sel_port = (mode_reg == MODE_PORT_PIN);
  wire sel_dual = (mode_reg == MODE_DUAL);
  wire drv_a_next = sel_port ? cpu_port_pin_in // see R1
                  : sel_dual ? gen_a_drive // see R7
                  : 1'b0;
  wire drv_b_next = (sel_port || sel_dual) ? gen_b_drive // see R2 see R7
                  : 1'b0;

  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      drv_a_reg <= 1'b0;
      drv_b_reg <= 1'b0;
    end
    else
    begin
      drv_a_reg <= drv_a_next;
      drv_b_reg <= drv_b_next;
    end
  end

  // read selection
  wire [DATA_W-1:0] status_word;
  assign status_word = {{(DATA_W-4){1'b0}}, drv_b_reg, drv_a_reg,
                        gen_b_busy, gen_a_busy};
  wire [DATA_W-1:0] enable_word;
  assign enable_word = {{(DATA_W-2){1'b0}}, gen_b_busy, gen_a_busy};

  wire [DATA_W-1:0] rd_value =
      (addr_in == OFF_MODE) ? {{(DATA_W-MODE_W){1'b0}}, mode_reg}
    : (addr_in == OFF_ENABLE) ? enable_word
    : (addr_in == OFF_HIGH_TIME_A) ? {{(DATA_W-TIME_W){1'b0}}, high_time_a_reg}
    : (addr_in == OFF_LOW_TIME_A) ? {{(DATA_W-TIME_W){1'b0}}, low_time_a_reg}
    : (addr_in == OFF_HIGH_TIME_B) ? {{(DATA_W-TIME_W){1'b0}}, high_time_b_reg}
    : (addr_in == OFF_LOW_TIME_B) ? {{(DATA_W-TIME_W){1'b0}}, low_time_b_reg}
    : (addr_in == OFF_COUNT_A) ? {{(DATA_W-COUNT_W){1'b0}}, count_a_reg}
    : (addr_in == OFF_COUNT_B) ? {{(DATA_W-COUNT_W){1'b0}}, count_b_reg}
    : (addr_in == OFF_STATUS) ? status_word
    : '0;

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      rdata_reg <= '0;
    else if (rd_in)
      rdata_reg <= rd_value;
    else
      rdata_reg <= '0;
  end

  assign rdata_out = rdata_reg;
  assign low_side_driver_a_out = drv_a_reg;
  assign low_side_driver_b_out = drv_b_reg;

endmodule // dual_burst_generator

// file: dual_burst_checker.sv
`timescale 1ns/1ps
module dual_burst_checker
  import dual_burst_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic [dual_burst_pkg::ADDR_W-1:0] addr_in, // index
  input wire logic [dual_burst_pkg::DATA_W-1:0] wdata_in, // data
  input wire logic wr_in, // write
  input wire logic rd_in, // read
  input wire logic cpu_port_pin_in, // pin
  input wire logic [dual_burst_pkg::DATA_W-1:0] rdata_out, // read data
  input wire logic low_side_driver_a_out, // driver a
  input wire logic low_side_driver_b_out // driver b
);
  import dual_burst_pkg::*;
  logic [2:0] mode_q;
  logic [10:0] ht_q [2];
  logic [10:0] hl_q [2];
  logic [10:0] run_q [2];
  logic [5:0] ct_q [2];
  logic [5:0] cl_q [2];
  logic [5:0] pc_q [2];
  wire [1:0] drv = {low_side_driver_b_out, low_side_driver_a_out};
  wire [1:0] trig = {2{wr_in && addr_in == OFF_ENABLE}} & wdata_in[1:0];
  wire dual = mode_q == MODE_DUAL;
  // shadows latch at the trigger, as the generator does
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode_q <= MODE_RST;
      for (int i = 0; i < 2; i++)
      begin
        ht_q[i] <= TIME_RST;
        hl_q[i] <= TIME_RST;
        ct_q[i] <= COUNT_RST;
        cl_q[i] <= COUNT_RST;
        pc_q[i] <= 6'h00;
        run_q[i] <= 11'h000;
      end
    end
    else
    begin
      if (wr_in && addr_in == OFF_MODE)
        mode_q <= wdata_in[2:0];
      for (int i = 0; i < 2; i++)
      begin
        if (wr_in && addr_in == ADDR_W'(2 + 2 * i))
          ht_q[i] <= wdata_in[10:0];
        if (wr_in && addr_in == ADDR_W'(6 + i))
          ct_q[i] <= wdata_in[5:0];
        run_q[i] <= drv[i] ? run_q[i] + 11'h001 : 11'h000;
        if (trig[i])
        begin
          hl_q[i] <= ht_q[i];
          cl_q[i] <= ct_q[i];
          pc_q[i] <= 6'h00;
        end
        else if (drv[i] && run_q[i] == 11'h000)
          pc_q[i] <= pc_q[i] + 6'h01;
      end
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence go_a;
    trig[0] && dual && ct_q[0] != 6'h00;
  endsequence
  sequence go_b;
    trig[1] && mode_q[2:1] == 2'h1 && ct_q[1] != 6'h00;
  endsequence
  sequence pin_still;
    mode_q == MODE_PORT_PIN && $past(mode_q, 3) == MODE_PORT_PIN &&
      $stable(cpu_port_pin_in) && $past(cpu_port_pin_in, 2) ==
      cpu_port_pin_in && $past(cpu_port_pin_in, 3) == cpu_port_pin_in;
  endsequence
  port_route_a: assert property (
    pin_still |-> drv[0] == cpu_port_pin_in) else $error("pin not routed");
  start_a_a: assert property (
    go_a |-> ##2 drv[0]) else $error("burst a late");
  start_b_a: assert property (
    go_b |-> ##2 drv[1]) else $error("burst b late");
  zero_a_a: assert property (
    trig[0] && dual && ct_q[0] == 6'h00 |-> ##2 !drv[0] [*4])
    else $error("empty burst a pulsed");
  high_a_a: assert property (
    $fell(drv[0]) && dual |-> run_q[0] == hl_q[0]) else $error("high a");
  high_b_a: assert property (
    $fell(drv[1]) |-> run_q[1] == hl_q[1]) else $error("high b");
  count_a_a: assert property (
    $rose(drv[0]) && dual |-> pc_q[0] < cl_q[0]) else $error("extra a");
  count_b_a: assert property (
    $rose(drv[1]) |-> pc_q[1] < cl_q[1]) else $error("extra b");
endmodule // dual_burst_checker
bind dual_burst_generator dual_burst_checker u_chk (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .cpu_port_pin_in(cpu_port_pin_in),
  .rdata_out(rdata_out), .low_side_driver_a_out(low_side_driver_a_out),
  .low_side_driver_b_out(low_side_driver_b_out));

// file: low_side_load.sv
`timescale 1ns/1ps
module low_side_load
(
  input wire logic clk_in, // clock
  input wire logic line_in, // driver gate
  input wire logic clear_in, // zero the tally
  output logic [6:0] pulses_out = 7'h00, // rising edges seen
  output logic [11:0] high_out = 12'h000, // last high run
  output logic [11:0] low_out = 12'h000 // last low run before a rise
);
  logic last_q = 1'b0;
  logic [11:0] run_q = 12'h000;
  always @(posedge clk_in)
  begin
    last_q <= line_in;
    run_q <= (line_in == last_q) ? run_q + 12'h001 : 12'h001;
    if (clear_in)
      pulses_out <= 7'h00;
    else if (line_in && !last_q)
      pulses_out <= pulses_out + 7'h01;
    if (!line_in && last_q)
      high_out <= run_q;
    if (line_in && !last_q)
      low_out <= run_q;
  end
endmodule // low_side_load

// file: dual_burst_generator_test.sv
`timescale 1ns/1ps
module dual_burst_generator_test;
  import dual_burst_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic pin = 1'b0;
  logic clear = 1'b0;
  wire [15:0] rdata;
  wire drv_a;
  wire drv_b;
  wire [6:0] np_a;
  wire [6:0] np_b;
  wire [11:0] hi_a;
  wire [11:0] hi_b;
  wire [11:0] lo_a;
  wire [11:0] lo_b;
  int errors = 0;
  int n_tests = 0;
  always #50 clk_in = ~clk_in;
  dual_burst_generator u_dual_burst_generator (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .cpu_port_pin_in(pin),
    .rdata_out(rdata), .low_side_driver_a_out(drv_a),
    .low_side_driver_b_out(drv_b));
  low_side_load u_load_a (.clk_in(clk_in), .line_in(drv_a),
    .clear_in(clear), .pulses_out(np_a), .high_out(hi_a), .low_out(lo_a));
  low_side_load u_load_b (.clk_in(clk_in), .line_in(drv_b),
    .clear_in(clear), .pulses_out(np_b), .high_out(hi_b), .low_out(lo_b));
  task automatic close_out;
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, s);
    n_tests++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      errors++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    d = rdata;
  endtask
  task automatic rc(input string n, input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask
  task automatic flush;
    @(posedge clk_in);
    clear <= 1'b1;
    @(posedge clk_in);
    clear <= 1'b0;
  endtask
  // runs both generators; a counts only while routed to its driver
  task automatic burst(input logic [10:0] ha, la, hb, lb,
    input logic [5:0] na, nb, input bit ra);
    logic [15:0] s;
    wr(OFF_HIGH_TIME_A, {5'h00, ha});
    wr(OFF_LOW_TIME_A, {5'h00, la});
    wr(OFF_HIGH_TIME_B, {5'h00, hb});
    wr(OFF_LOW_TIME_B, {5'h00, lb});
    wr(OFF_COUNT_A, {10'h000, na});
    wr(OFF_COUNT_B, {10'h000, nb});
    flush();
    wr(OFF_ENABLE, 16'h0003);
    s = 16'h0003;
    for (int i = 0; i < 4000 && s[1:0] != 2'h0; i++)
      rd(OFF_STATUS, s);
    chk("busy", 16'h0000, {14'h0000, s[1:0]});
    chk("pulses a", ra ? 16'(na) : 16'h0000, 16'(np_a));
    chk("pulses b", 16'(nb), 16'(np_b));
    chk("high b", 16'(hb), 16'(hi_b));
    chk("low b", 16'(lb), 16'(lo_b));
    if (ra)
    begin
      chk("high a", 16'(ha), 16'(hi_a));
      chk("low a", 16'(la), 16'(lo_a));
    end
  endtask
  initial
  begin
    repeat (30000) @(posedge clk_in);
    errors++;
    close_out();
  end
  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rc("mode", OFF_MODE, 16'h0003);
    for (int i = 2; i < 6; i++)
      rc("time", 4'(i), 16'h0008);
    rc("count a", OFF_COUNT_A, 16'h0000);
    rc("count b", OFF_COUNT_B, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rc("unmapped", 4'hF, 16'h0000);
    wr(OFF_HIGH_TIME_A, 16'hFFFF);
    rc("time a", OFF_HIGH_TIME_A, 16'h07FF);
    wr(OFF_COUNT_B, 16'hFFFF);
    rc("count b", OFF_COUNT_B, 16'h003F);
    burst(11'h003, 11'h002, 11'h001, 11'h004, 6'h05, 6'h3F, 1);
    burst(11'h7FF, 11'h001, 11'h001, 11'h7FF, 6'h02, 6'h02, 1);
    wr(OFF_COUNT_A, 16'h0000);
    flush();
    wr(OFF_ENABLE, 16'h0001);
    repeat (20) @(posedge clk_in);
    chk("empty a", 16'h0000, 16'(np_a));
    chk("idle b", 16'h0000, 16'(np_b));
    wr(OFF_MODE, 16'h0002);
    rc("mode", OFF_MODE, 16'h0002);
    // read returns mid-cycle; step to a rising edge before driving
    @(posedge clk_in);
    pin <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("pin high", 16'h0001, 16'(drv_a));
    pin <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk("pin low", 16'h0000, 16'(drv_a));
    // an unsupported code must block the pin from driver A
    pin <= 1'b1;
    wr(OFF_MODE, 16'h0005);
    repeat (2) @(posedge clk_in);
    chk("other mode", 16'h0000, 16'(drv_a));
    pin <= 1'b0;
    wr(OFF_MODE, 16'h0002);
    burst(11'h002, 11'h002, 11'h002, 11'h003, 6'h04, 6'h03, 0);
    close_out();
  end
endmodule // dual_burst_generator_test
